// file: hdl/usr_consts.vh
// Constants for the four-stage universal shift register.
// Assumes inclusion by bare name from design files only.
// How it works
// R1: Four stages A to D, both shifts, load
// R2: Clear low forces all stages low; the code ignores clear while clk_en is low
// R3: Clock low with clear high holds all
// R4: Only rising clock edge changes stages
// R5: Both selects high loads parallel inputs
// R6: Parallel load ignores both serial inputs
// R7: Upper low, lower high shifts right
// R8: Right shift enters at A towards D
// R9: Upper high, lower low shifts left
// R10: Left shift enters at D towards A
// R11: Both selects low holds all stages
`ifndef USR_CONSTS_VH
`define USR_CONSTS_VH
`define USR_WIDTH 4
`define USR_RESET_VAL 4'h0
`define USR_MODE_HOLD 2'h0
`define USR_MODE_RIGHT 2'h1
`define USR_MODE_LEFT 2'h2
`define USR_MODE_LOAD 2'h3
`define USR_POS_A 0
`define USR_POS_D 3
`endif

// file: hdl/usr_shift_reg.v
// Four-stage bidirectional universal shift register.
// Assumes pin inputs are asynchronous; clear, mode and data are synchronised.
// Outputs follow a pin change by three enabled edges.
`timescale 1ns/1ns
`include "usr_consts.vh"
module usr_shift_reg (
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  input wire clear_n,
  input wire mode_select_upper,
  input wire mode_select_lower,
  input wire serial_left,
  input wire serial_right,
  input wire [`USR_WIDTH-1:0] parallel_in,
  output wire stage_a,
  output wire stage_b,
  output wire stage_c,
  output wire stage_d
);
  // Synchronised control and serial pins
  wire clear_n_s;
  wire upper_s;
  wire lower_s;
  wire left_s;
  wire right_s;

  // Synchronised parallel pins
  wire par_a_s;
  wire par_b_s;
  wire par_c_s;
  wire par_d_s;

  // Mode from the synchronised selects
  wire [1:0] mode_s;

  // R1: one flop per stage
  reg stage_a_reg;
  reg stage_b_reg;
  reg stage_c_reg;
  reg stage_d_reg;

  // Next levels, combinational
  reg stage_a_next;
  reg stage_b_next;
  reg stage_c_next;
  reg stage_d_next;

  // Reset level of each stage, from one vector
  localparam [`USR_WIDTH-1:0] RESET_VEC = `USR_RESET_VAL;

  // Same two-edge delay on every pin keeps combinations aligned
  // Trades two edges of latency for metastability margin
  // Clear pin
  usr_sync #(
    .W(1)
  ) u_sync_clear (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d(clear_n),
    .q(clear_n_s)
  );

  // Upper select pin
  usr_sync #(
    .W(1)
  ) u_sync_upper (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d(mode_select_upper),
    .q(upper_s)
  );

  // Lower select pin
  usr_sync #(
    .W(1)
  ) u_sync_lower (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d(mode_select_lower),
    .q(lower_s)
  );

  // Left serial pin
  usr_sync #(
    .W(1)
  ) u_sync_left (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d(serial_left),
    .q(left_s)
  );

  // Right serial pin
  usr_sync #(
    .W(1)
  ) u_sync_right (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d(serial_right),
    .q(right_s)
  );

  // Parallel pin of stage A
  usr_sync #(
    .W(1)
  ) u_sync_par_a (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d(parallel_in[`USR_POS_A]),
    .q(par_a_s)
  );

  // Parallel pin of stage B
  usr_sync #(
    .W(1)
  ) u_sync_par_b (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d(parallel_in[`USR_POS_A+1]),
    .q(par_b_s)
  );

  // Parallel pin of stage C
  usr_sync #(
    .W(1)
  ) u_sync_par_c (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d(parallel_in[`USR_POS_D-1]),
    .q(par_c_s)
  );

  // Parallel pin of stage D
  usr_sync #(
    .W(1)
  ) u_sync_par_d (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d(parallel_in[`USR_POS_D]),
    .q(par_d_s)
  );

  assign mode_s = {upper_s, lower_s};

  // Next level of one stage; one choice shared by all four
  // Sides are named as seen from the stage itself
  function usr_pick;
    input [1:0] mode;
    input own;
    input par;
    input from_a_side;
    input from_d_side;
    begin
      case (mode)
        // R5: load parallel
        // R6: serial ignored
        `USR_MODE_LOAD: begin
          usr_pick = par;
        end
        // R7: shift right
        // R8: A side feeds in
        `USR_MODE_RIGHT: begin
          usr_pick = from_a_side;
        end
        // R9: shift left
        // R10: D side feeds in
        `USR_MODE_LEFT: begin
          usr_pick = from_d_side;
        end
        // R11: hold mode
        default: begin
          usr_pick = own;
        end
      endcase
    end
  endfunction

  // Right shift pulls from the A side, left shift from the D side
  // Hold keeps each stage at its own level
  // Stage A: right serial enters here
  always @* begin
    stage_a_next = usr_pick(
      mode_s,
      stage_a_reg,
      par_a_s,
      right_s,
      stage_b_reg
    );
  end

  // Stage B
  always @* begin
    stage_b_next = usr_pick(
      mode_s,
      stage_b_reg,
      par_b_s,
      stage_a_reg,
      stage_c_reg
    );
  end

  // Stage C
  always @* begin
    stage_c_next = usr_pick(
      mode_s,
      stage_c_reg,
      par_c_s,
      stage_b_reg,
      stage_d_reg
    );
  end

  // Stage D: left serial enters here
  always @* begin
    stage_d_next = usr_pick(
      mode_s,
      stage_d_reg,
      par_d_s,
      stage_c_reg,
      left_s
    );
  end

  // Stage A flop
  // R4: rising edge only
  always @(posedge clk) begin
    if (!rst_n) begin
      stage_a_reg <= RESET_VEC[`USR_POS_A];
    end else if (!clk_en) begin
      // R3: frozen without enable
      stage_a_reg <= stage_a_reg;
    end else if (!clear_n_s) begin
      // R2: clear beats mode
      stage_a_reg <= RESET_VEC[`USR_POS_A];
    end else begin
      stage_a_reg <= stage_a_next;
    end
  end

  // Stage B flop
  // R4: rising edge only
  always @(posedge clk) begin
    if (!rst_n) begin
      stage_b_reg <= RESET_VEC[`USR_POS_A+1];
    end else if (!clk_en) begin
      // R3: frozen without enable
      stage_b_reg <= stage_b_reg;
    end else if (!clear_n_s) begin
      // R2: clear beats mode
      stage_b_reg <= RESET_VEC[`USR_POS_A+1];
    end else begin
      stage_b_reg <= stage_b_next;
    end
  end

  // Stage C flop
  // R4: rising edge only
  always @(posedge clk) begin
    if (!rst_n) begin
      stage_c_reg <= RESET_VEC[`USR_POS_D-1];
    end else if (!clk_en) begin
      // R3: frozen without enable
      stage_c_reg <= stage_c_reg;
    end else if (!clear_n_s) begin
      // R2: clear beats mode
      stage_c_reg <= RESET_VEC[`USR_POS_D-1];
    end else begin
      stage_c_reg <= stage_c_next;
    end
  end

  // Stage D flop
  // R4: rising edge only
  always @(posedge clk) begin
    if (!rst_n) begin
      stage_d_reg <= RESET_VEC[`USR_POS_D];
    end else if (!clk_en) begin
      // R3: frozen without enable
      stage_d_reg <= stage_d_reg;
    end else if (!clear_n_s) begin
      // R2: clear beats mode
      stage_d_reg <= RESET_VEC[`USR_POS_D];
    end else begin
      stage_d_reg <= stage_d_next;
    end
  end

  // R1: outputs straight from the stage flops
  assign stage_a = stage_a_reg;
  assign stage_b = stage_b_reg;
  assign stage_c = stage_c_reg;
  assign stage_d = stage_d_reg;

endmodule // usr_shift_reg

// file: hdl/usr_sync.v
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes inputs asynchronous to clk; clk_en freezes it too.
`timescale 1ns/1ns
module usr_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (clk_en) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // usr_sync

// file: testbench/tb.sv
// Bench for the shift register.
// Assumes usr_drv feeds the pins.
`timescale 1ns/1ns
module tb;
  logic clk = 0, rst_n = 0, en = 1;
  logic [8:0] v = 9'h0, p;
  wire [3:0] q;
  int bad_count = 0, num_checks = 0;
  always #50 clk = ~clk;
  usr_drv i_usr_drv(.clk(clk), .v(v), .p(p));
  usr_shift_reg i_usr_shift_reg(.clk(clk), .rst_n(rst_n), .clk_en(en), .clear_n(p[8]),
    .mode_select_upper(p[7]), .mode_select_lower(p[6]), .serial_left(p[5]), .serial_right(p[4]),
    .parallel_in(p[3:0]), .stage_a(q[0]), .stage_b(q[1]), .stage_c(q[2]), .stage_d(q[3]));
  task check(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value stages expected %h seen %h", exp, seen);
    end
  endtask
  // One enabled edge of x, then hold; stages settle after the third edge
  task step(input logic [8:0] x);
    @(posedge clk) v = x;
    @(posedge clk) v = 9'h100;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task load_scenario;
    step(9'h1fa);
    check(q, 4'ha);
  endtask
  task right_scenario;
    step(9'h155);
    check(q, 4'h5);
  endtask
  task left_scenario;
    step(9'h1a0);
    check(q, 4'ha);
  endtask
  task hold_scenario;
    step(9'h13f);
    check(q, 4'ha);
  endtask
  task right_zero_scenario;
    step(9'h140);
    check(q, 4'h4);
  endtask
  // Load levels on the pins while frozen must not reach the stages
  task freeze_scenario;
    @(negedge clk) en = 0;
    v = 9'h1ff;
    repeat (6) @(posedge clk);
    #1 check(q, 4'h4);
    v = 9'h100;
    repeat (2) @(negedge clk);
    en = 1;
    repeat (4) @(posedge clk);
    #1 check(q, 4'h4);
  endtask
  task clear_scenario;
    step(9'h0ff);
    check(q, 4'h0);
  endtask
  task finish_test;
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    load_scenario;
    right_scenario;
    left_scenario;
    hold_scenario;
    right_zero_scenario;
    freeze_scenario;
    clear_scenario;
    finish_test;
  end
endmodule // tb

// file: testbench/usr_drv.sv
// Partner logic driving the pins.
// Assumes the bench supplies the next levels.
`timescale 1ns/1ns
module usr_drv(input wire clk, input wire [8:0] v, output logic [8:0] p = 9'h0);
  // Falling edge keeps setup clear of the rising edge
  always @(negedge clk) p <= v;
endmodule // usr_drv

// file: testbench/usr_props.sv
// Port checker for the shift register.
// Assumes a three-edge pin latency.
`timescale 1ns/1ns
module usr_props(input wire clk, rst_n, clk_en, clear_n, mode_select_upper, mode_select_lower,
  serial_left, serial_right, stage_a, stage_b, stage_c, stage_d, input wire [3:0] parallel_in);
  logic [3:0] h = 4'h0;
  wire ok = &h;
  wire [3:0] q = {stage_d, stage_c, stage_b, stage_a};
  wire [2:0] c = {clear_n, mode_select_upper, mode_select_lower};
  default clocking @(posedge clk); endclocking
  default disable iff (!ok);
  // Sync stages need four live edges
  always @(posedge clk) h <= {h[2:0], rst_n & clk_en};
  a_clear_low: assert property (!$past(clear_n,3) |-> !q) else $error("bad");
  a_hold_mode: assert property ($past(c,3) == 3'h4 |-> $stable(q)) else $error("bad");
  a_par_load: assert property ($past(c,3) == 3'h7 |-> q == $past(parallel_in,3)) else $error("bad");
  a_right_shift: assert property ($past(c,3) == 3'h5 |-> q == {$past(q[2:0]), $past(serial_right,3)})
    else $error("bad");
  a_left_shift: assert property ($past(c,3) == 3'h6 |-> q == {$past(serial_left,3), $past(q[3:1])})
    else $error("bad");
  a_change_cause: assert property ($changed(q) |-> $past(c,3) != 3'h4) else $error("bad");
  a_load_kept: assert property ($past(c,4) == 3'h7 && $past(c,3) == 3'h4 |-> q == $past(parallel_in,4))
    else $error("bad");
endmodule // usr_props
bind usr_shift_reg usr_props i_p(.*);
